// file: pkg/scb_pkg.sv
// package: field layout and encodings of the servo command/status bytes
package scb_pkg;
    localparam int MSG_BYTES = 8;
    // general command byte
    localparam int CMD_FMT_BIT = 7;
    localparam int CMD_CLR_BIT = 5;
    localparam int CMD_HALT_BIT = 4;
    localparam int CMD_DRV_BIT = 1;
    localparam int CMD_EXE_BIT = 0;
    // move byte 2 / byte 3
    localparam int MV_ZERO_BIT = 7;
    localparam int MV_TABLE_BIT = 6;
    localparam int MV_STATION_BIT = 5;
    localparam int MV_INC_BIT = 4;
    localparam int MV_CONST_BIT = 3;
    localparam int MV_PAUSE_BIT = 1;
    localparam int MV_ABORT_BIT = 0;
    localparam int MV_REV_BIT = 1;
    localparam int MV_REL_BIT = 0;
    // move command codes
    localparam logic [3:0] CODE_NOP = 4'h0;
    localparam logic [3:0] CODE_SIMPLE = 4'h1;
    localparam logic [3:0] CODE_EXT = 4'h2;
    localparam logic [3:0] CODE_NOTCH = 4'h3;
    localparam logic [3:0] CODE_MULTI = 4'h4;
    // response types
    localparam logic [3:0] RSP_CMD_POS = 4'h0;
    localparam logic [3:0] RSP_CUR_POS = 4'h1;
    localparam logic [3:0] RSP_POS_ERR = 4'h2;
    localparam logic [3:0] RSP_CMD_SPD = 4'h3;
    localparam logic [3:0] RSP_CUR_SPD = 4'h4;
    localparam logic [3:0] RSP_TORQUE = 4'h5;
    localparam logic [3:0] RSP_STATION = 4'ha;
    localparam logic [3:0] RSP_TABLE = 4'hb;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    typedef enum logic [2:0] {
        MV_IDLE = 3'b001,
        MV_RUN = 3'b010,
        MV_STOP = 3'b100
    } scb_mv_e;
endpackage

// file: verilog/scb_core.sv
// servo command interpreter: decodes command byte 0 and move bytes, builds status byte 0
`timescale 1ns/1ps
// Overview of operation
// - command and response messages are eight bytes; byte 0 general, 1-7 data
// - command bit 7 picks move or set/read layout for bytes 1 to 7
// - command bits: 5 alarm clear, 4 halt, 1 drive enable, 0 execute
// - alarm clear request wipes current alarms and warnings
// - halt falling edge cancels move, stops travel, drive off once stopped
// - halt is active low; emergency stop lasts while it is 0
// - after emergency stop, enable must go 0 then 1 to restart drive
// - drive on at enable rising edge, stays while 1, off when 0
// - after alarm trip, enable must toggle 0 then 1 before restart
// - execute rising edge starts the selected command with presented data
// - status bits: 7 format, 6 ready, 5 supply, 4 halt, 3 fault, 2 caution
// - format echo equals the received format select bit
// - ready low during enable, parameter access, power-up, module reset, init
// - supply flag follows main power; without it enable and commands refused
// - halt state flag is 1 while halt request is 0
// - fault flag sets on alarm, clears only through alarm clear
// - caution flag sets on warning; blocks data-setting commands only
// - drive enabled flag needs enable 1, drive on, no halt, reset, alarm
// - execute ack mirrors the received execute request
// - move byte 1: response type high, code low; byte 2 motion bits
// - move byte 3: reverse bit 1, relative bit 0; bytes 4-7 data
// - move codes 0 to 4: nop, simple, external, notch, multi-speed
// - response types 0-5, 10, 11 select the response data
// - abort stops and discards travel; ends at target, not in progress
// - in progress flag high while executing, low on completion or stop
module scb_core #(
    parameter int INIT_CYCLES = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic msg_valid,
    input wire logic [7:0] cmd_b0,
    input wire logic [7:0] cmd_b1,
    input wire logic [7:0] cmd_b2,
    input wire logic [7:0] cmd_b3,
    input wire logic main_power,
    input wire logic alarm_event,
    input wire logic warning_event,
    input wire logic motor_stopped,
    input wire logic move_done,
    input wire logic param_busy,
    input wire logic module_reset,
    input wire logic data_set_cmd,
    output logic [7:0] status_b0,
    output logic drive_on,
    output logic axis_stop,
    output logic move_start,
    output logic [3:0] move_code,
    output logic [3:0] rsp_sel,
    output logic reverse_select,
    output logic relative_select,
    output logic in_progress_flag,
    output logic at_target_flag,
    output logic data_set_start
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] pwr_s;
    logic [1:0] alm_s;
    logic [1:0] wrn_s;
    logic [1:0] stp_s;
    logic [1:0] done_s;
    logic [1:0] prm_s;
    logic [1:0] mrst_s;
    // pins from the drive side are asynchronous, two stages each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_s <= scb_pkg::SYNC_RESET;
            alm_s <= scb_pkg::SYNC_RESET;
            wrn_s <= scb_pkg::SYNC_RESET;
            stp_s <= scb_pkg::SYNC_RESET;
            done_s <= scb_pkg::SYNC_RESET;
            prm_s <= scb_pkg::SYNC_RESET;
            mrst_s <= scb_pkg::SYNC_RESET;
        end else begin
            pwr_s <= {pwr_s[0], main_power};
            alm_s <= {alm_s[0], alarm_event};
            wrn_s <= {wrn_s[0], warning_event};
            stp_s <= {stp_s[0], motor_stopped};
            done_s <= {done_s[0], move_done};
            prm_s <= {prm_s[0], param_busy};
            mrst_s <= {mrst_s[0], module_reset};
        end
    end
    wire logic pwr = pwr_s[1];
    wire logic stopped = stp_s[1];
    wire logic mrst = mrst_s[1];

    // ************************************************************
    // command byte capture and edges
    // ************************************************************
    // of byte 0 only bits 7, 5, 4, 1, 0 are looked at; reserved bits 6, 3, 2 are ignored
    logic fmt;
    logic clr;
    logic halt_n;
    logic drv_req;
    logic exe_req;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt <= 1'b0;
            clr <= 1'b0;
            halt_n <= 1'b1;
            drv_req <= 1'b0;
            exe_req <= 1'b0;
            b1 <= scb_pkg::RESET_BYTE;
            b2 <= scb_pkg::RESET_BYTE;
            b3 <= scb_pkg::RESET_BYTE;
        end else if (msg_valid) begin
            fmt <= cmd_b0[scb_pkg::CMD_FMT_BIT];
            clr <= cmd_b0[scb_pkg::CMD_CLR_BIT];
            halt_n <= cmd_b0[scb_pkg::CMD_HALT_BIT];
            drv_req <= cmd_b0[scb_pkg::CMD_DRV_BIT];
            exe_req <= cmd_b0[scb_pkg::CMD_EXE_BIT];
            b1 <= cmd_b1; // bytes 1-3 latched on the same message as byte 0
            b2 <= cmd_b2;
            b3 <= cmd_b3;
        end
    end
    logic halt_d;
    logic drv_d;
    logic exe_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_d <= 1'b1;
            drv_d <= 1'b0;
            exe_d <= 1'b0;
        end else begin
            halt_d <= halt_n;
            drv_d <= drv_req;
            exe_d <= exe_req;
        end
    end
    wire logic halt_fall = halt_d && !halt_n;
    wire logic drv_rise = drv_req && !drv_d;
    wire logic exe_rise = exe_req && !exe_d;
    wire logic is_move = !fmt;

    // ************************************************************
    // alarm and warning flags
    // ************************************************************
    // set wins over a clear arriving in the same cycle
    logic fault;
    logic caution;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault <= 1'b0;
            caution <= 1'b0;
        end else begin
            fault <= alm_s[1] || (fault && !clr);
            caution <= wrn_s[1] || (caution && !clr);
        end
    end

    // ************************************************************
    // init count-up after reset, and ready
    // ************************************************************
    logic [15:0] init_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt <= 16'h0000;
        end else if (mrst) begin
            init_cnt <= 16'h0000; // module reset restarts initialisation
        end else if (init_cnt != 16'(INIT_CYCLES)) begin
            init_cnt <= init_cnt + 16'h0001;
        end
    end
    wire logic init_busy = (init_cnt != 16'(INIT_CYCLES)) || mrst;
    logic drv_settle;
    wire logic ready = !init_busy && !prm_s[1] && !drv_settle && pwr;

    // ************************************************************
    // drive enable
    // ************************************************************
    // drive only restarts on a fresh rising edge, so a level held at 1
    // through a halt or alarm never restarts the motor on its own
    logic drv;
    logic stopping;
    wire logic drv_block = !halt_n || fault || mrst || !pwr;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drv <= 1'b0;
            drv_settle <= 1'b0;
        end else begin
            drv_settle <= drv_rise && !drv_block; // ready dips while enabling
            if (!drv_req || fault || mrst || !pwr) begin
                drv <= 1'b0;
            end else if (!halt_n) begin
                if (stopped) begin
                    drv <= 1'b0; // off once the motor rests
                end
            end else if (drv_rise) begin
                drv <= 1'b1;
            end
        end
    end

    // ************************************************************
    // move sequencer
    // ************************************************************
    scb_pkg::scb_mv_e mv;
    wire logic code_ok = b1[3:0] inside {scb_pkg::CODE_SIMPLE, scb_pkg::CODE_EXT,
        scb_pkg::CODE_NOTCH, scb_pkg::CODE_MULTI};
    wire logic abort = b2[scb_pkg::MV_ABORT_BIT];
    wire logic go = exe_rise && is_move && code_ok && ready && drv && halt_n && !abort;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mv <= scb_pkg::MV_IDLE;
            stopping <= 1'b0;
        end else begin
            unique case (mv)
                scb_pkg::MV_IDLE: begin
                    if (go) begin
                        mv <= scb_pkg::MV_RUN;
                    end
                end
                scb_pkg::MV_RUN: begin
                    if (halt_fall || !halt_n || abort || !drv) begin
                        mv <= scb_pkg::MV_STOP;
                    end else if (done_s[1]) begin
                        mv <= scb_pkg::MV_IDLE;
                    end
                end
                scb_pkg::MV_STOP: begin
                    if (stopped) begin
                        mv <= scb_pkg::MV_IDLE; // remaining travel discarded
                    end
                end
                default: begin
                    mv <= scb_pkg::MV_IDLE;
                end
            endcase
            stopping <= (mv == scb_pkg::MV_RUN) && (!halt_n || abort || !drv);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // status byte and drive-side strobes, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_b0 <= scb_pkg::RESET_BYTE;
            drive_on <= 1'b0;
            axis_stop <= 1'b0;
            move_start <= 1'b0;
            move_code <= scb_pkg::CODE_NOP;
            rsp_sel <= scb_pkg::RSP_CMD_POS;
            reverse_select <= 1'b0;
            relative_select <= 1'b0;
            in_progress_flag <= 1'b0;
            at_target_flag <= 1'b0;
            data_set_start <= 1'b0;
        end else begin
            status_b0 <= {fmt, ready, pwr, !halt_n, fault, caution,
                drv && drv_req && halt_n && !mrst && !fault, exe_req};
            drive_on <= drv;
            axis_stop <= halt_fall || stopping || (mv == scb_pkg::MV_STOP);
            move_start <= go;
            if (go) begin
                move_code <= b1[3:0];
            end
            // unlisted response types fall back to command position
            rsp_sel <= (b1[7:4] inside {scb_pkg::RSP_CMD_POS, scb_pkg::RSP_CUR_POS,
                scb_pkg::RSP_POS_ERR, scb_pkg::RSP_CMD_SPD, scb_pkg::RSP_CUR_SPD,
                scb_pkg::RSP_TORQUE, scb_pkg::RSP_STATION, scb_pkg::RSP_TABLE})
                ? b1[7:4] : scb_pkg::RSP_CMD_POS;
            reverse_select <= b3[scb_pkg::MV_REV_BIT];
            relative_select <= b3[scb_pkg::MV_REL_BIT];
            in_progress_flag <= (mv == scb_pkg::MV_RUN) && !(done_s[1] || abort || !halt_n);
            if (go) begin
                at_target_flag <= 1'b0;
            end else if (mv != scb_pkg::MV_IDLE && (done_s[1] || (mv == scb_pkg::MV_STOP
                && stopped && abort))) begin
                at_target_flag <= 1'b1;
            end
            // data setting blocked while a warning stands
            data_set_start <= exe_rise && fmt && data_set_cmd && !caution && ready && pwr;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    halt_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        msg_valid && !cmd_b0[scb_pkg::CMD_HALT_BIT] |-> ##2 status_b0[4])
        else $error("halt flag not raised");
    ack_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        msg_valid |-> ##2 status_b0[0] == $past(cmd_b0[scb_pkg::CMD_EXE_BIT], 2))
        else $error("execute ack wrong");
    fmt_echo_a: assert property (@(posedge clk) disable iff (!rst_n)
        msg_valid |-> ##2 status_b0[7] == $past(cmd_b0[scb_pkg::CMD_FMT_BIT], 2))
        else $error("format echo wrong");
    drv_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
        !halt_n |=> !status_b0[1])
        else $error("drive flag during halt");
    fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        fault && !clr |=> ##1 status_b0[3])
        else $error("fault cleared without request");
    sequence halt_seq;
        halt_d && !halt_n;
    endsequence
    halt_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        halt_seq |=> axis_stop)
        else $error("halt did not stop axis");
    no_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        !drv && drv_req && drv_d |=> !drv)
        else $error("drive restarted on level");
    nop_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        mv == scb_pkg::MV_IDLE && !code_ok |=> mv == scb_pkg::MV_IDLE)
        else $error("motion started on unlisted code");
    supply_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pwr |=> !move_start ##1 !drive_on)
        else $error("command ran without supply");
endmodule

// file: tb/scb_master_model.sv
// fieldbus master model: presents one command message per send strobe
`timescale 1ns/1ps
module scb_master_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [31:0] msg,
    output logic msg_valid,
    output logic [7:0] cmd_b0,
    output logic [7:0] cmd_b1,
    output logic [7:0] cmd_b2,
    output logic [7:0] cmd_b3
);
    // ************************************************************
    // message launch
    // ************************************************************
    // code, data and execute leave together in one message
    // between frames the bytes invert, so stale data never looks valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid <= 1'b0;
            {cmd_b0, cmd_b1, cmd_b2, cmd_b3} <= 32'h10000000;
        end else if (send) begin
            msg_valid <= 1'b1;
            // reserved bit positions always sent as zero
            {cmd_b0, cmd_b1, cmd_b2, cmd_b3} <= msg & 32'hb3fffb03;
        end else begin
            msg_valid <= 1'b0;
            {cmd_b0, cmd_b1, cmd_b2, cmd_b3} <= ~{cmd_b0, cmd_b1, cmd_b2, cmd_b3};
        end
    end
endmodule

// file: tb/servo_command_status_bits_tb.sv
// testbench: command byte decode and status byte checks of the servo command block
`timescale 1ns/1ps
module servo_command_status_bits_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic send = 1'b0;
    logic [31:0] msg = 32'h0;
    logic msg_valid;
    logic [7:0] cmd_b0, cmd_b1, cmd_b2, cmd_b3, status_b0;
    logic main_power = 1'b1, alarm_event = 1'b0, warning_event = 1'b0;
    logic motor_stopped = 1'b0, move_done = 1'b0, param_busy = 1'b0;
    logic module_reset = 1'b0, data_set_cmd = 1'b0;
    logic drive_on, axis_stop, move_start, reverse_select, relative_select;
    logic in_progress_flag, at_target_flag, data_set_start;
    logic [3:0] move_code, rsp_sel;
    int bad_count = 0, checked = 0, cyc = 0, n_mv = 0, n_ds = 0;

    // 4 ns clock
    always #2 clk = ~clk;

    scb_master_model master (.clk, .rst_n, .send, .msg, .msg_valid,
        .cmd_b0, .cmd_b1, .cmd_b2, .cmd_b3);

    // short init count keeps the run brief
    scb_core #(.INIT_CYCLES(2)) dut (.clk, .rst_n, .msg_valid, .cmd_b0, .cmd_b1,
        .cmd_b2, .cmd_b3, .main_power, .alarm_event, .warning_event, .motor_stopped,
        .move_done, .param_busy, .module_reset, .data_set_cmd, .status_b0, .drive_on,
        .axis_stop, .move_start, .move_code, .rsp_sel, .reverse_select,
        .relative_select, .in_progress_flag, .at_target_flag, .data_set_start);

    // pulses are counted, so checks need not land on the pulse cycle
    always @(posedge clk) begin
        if (move_start === 1'b1) n_mv <= n_mv + 1;
        if (data_set_start === 1'b1) n_ds <= n_ds + 1;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] g(int f, int cl, int h, int e, int x);
        return {f[0], 1'b0, cl[0], h[0], 2'b00, e[0], x[0]};
    endfunction

    task c(input string n, input logic [7:0] e, input logic [7:0] v);
        checked++;
        if (v !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, v);
        end
    endtask

    // ten cycles cover the input synchronisers and status registers
    task s;
        repeat (10) @(posedge clk);
        #1;
    endtask

    task m(input logic [31:0] v);
        @(posedge clk) begin
            send <= 1'b1;
            msg <= v;
        end
        @(posedge clk) send <= 1'b0;
        s();
    endtask

    task en_toggle;
        m({g(0, 0, 1, 0, 0), 24'h0});
        m({g(0, 0, 1, 1, 0), 24'h0});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_idle;
        c("rst_status", 8'h00, status_b0);
        @(posedge clk) rst_n <= 1'b1;
        m({g(0, 0, 1, 0, 0), 24'h0});
        c("idle_status", 8'h60, status_b0);
        m({g(0, 0, 1, 1, 0), 24'h0});
        c("drive_on", 8'h01, {7'h0, drive_on});
        c("drv_status", 8'h62, status_b0);
    endtask

    task t_move;
        logic [3:0] cd [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h7};
        int n;
        logic go;
        for (int i = 0; i < 6; i++) begin
            n = n_mv;
            go = cd[i] inside {[4'h1:4'h4]};
            m({g(0, 0, 1, 1, 1), 4'h1, cd[i], 8'h00, 6'h0, i[1:0]});
            c("starts", 8'(go), 8'(n_mv - n));
            c("ack", 8'h01, {7'h0, status_b0[0]});
            if (go) begin
                c("code", {4'h0, cd[i]}, {4'h0, move_code});
                c("dir_inc", {6'h0, i[1:0]}, {6'h0, reverse_select, relative_select});
                c("busy", 8'h01, {7'h0, in_progress_flag});
                @(posedge clk) move_done <= 1'b1;
                s();
                c("done", 8'h02, {6'h0, at_target_flag, in_progress_flag});
                @(posedge clk) move_done <= 1'b0;
            end
            m({g(0, 0, 1, 1, 0), 24'h0});
            c("ack_low", 8'h00, {7'h0, status_b0[0]});
        end
    endtask

    task t_rsp;
        logic [3:0] r [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'hb, 4'h6, 4'hf};
        for (int i = 0; i < 10; i++) begin
            m({g(0, 0, 1, 1, 0), r[i], 4'h0, 16'h0});
            c("rsp_sel", {4'h0, (i < 8) ? r[i] : 4'h0}, {4'h0, rsp_sel});
        end
    endtask

    task t_fmt_abort;
        int n;
        n = n_mv;
        m({g(1, 0, 1, 1, 1), 8'h01, 16'h0});
        c("fmt_start", 8'h00, 8'(n_mv - n));
        c("fmt_echo", 8'h01, {7'h0, status_b0[7]});
        m({g(0, 0, 1, 1, 0), 24'h0});
        c("fmt_echo0", 8'h00, {7'h0, status_b0[7]});
        m({g(0, 0, 1, 1, 1), 8'h01, 16'h0});
        m({g(0, 0, 1, 1, 1), 8'h01, 8'h01, 8'h00});
        c("abort_wait", 8'h00, {6'h0, at_target_flag, in_progress_flag});
        c("abort_stop", 8'h01, {7'h0, axis_stop});
        // the abort only completes once the motor has come to rest
        @(posedge clk) motor_stopped <= 1'b1;
        s();
        c("abort", 8'h02, {6'h0, at_target_flag, in_progress_flag});
        @(posedge clk) motor_stopped <= 1'b0;
        m({g(0, 0, 1, 1, 0), 24'h0});
    endtask

    task t_halt;
        m({g(0, 0, 1, 1, 1), 8'h01, 16'h0});
        m({g(0, 0, 0, 1, 1), 8'h01, 16'h0});
        c("halt_st", 8'h10, status_b0 & 8'h12);
        c("halt_mv", 8'h01, {6'h0, in_progress_flag, axis_stop});
        c("drv_wait", 8'h01, {7'h0, drive_on});
        @(posedge clk) motor_stopped <= 1'b1;
        s();
        c("drv_stop", 8'h00, {7'h0, drive_on});
        m({g(0, 0, 1, 1, 0), 24'h0});
        c("halt_rel", 8'h00, status_b0 & 8'h12);
        c("no_auto", 8'h00, {7'h0, drive_on});
        @(posedge clk) motor_stopped <= 1'b0;
        en_toggle();
        c("re_on", 8'h01, {7'h0, drive_on});
    endtask

    task t_alarm;
        @(posedge clk) alarm_event <= 1'b1;
        s();
        c("fault", 8'h08, status_b0 & 8'h0a);
        c("flt_off", 8'h00, {7'h0, drive_on});
        @(posedge clk) alarm_event <= 1'b0;
        s();
        c("flt_hold", 8'h08, status_b0 & 8'h0a);
        m({g(0, 1, 1, 1, 0), 24'h0});
        c("flt_clr", 8'h00, status_b0 & 8'h0a);
        m({g(0, 0, 1, 1, 0), 24'h0});
        c("lvl_on", 8'h00, {7'h0, drive_on});
        en_toggle();
        c("edge_on", 8'h01, {7'h0, drive_on});
    endtask

    task t_warn;
        int n;
        n = n_ds;
        @(posedge clk) begin
            warning_event <= 1'b1;
            data_set_cmd <= 1'b1;
        end
        s();
        c("caution", 8'h04, status_b0 & 8'h04);
        m({g(1, 0, 1, 1, 1), 24'h0});
        c("set_block", 8'h00, 8'(n_ds - n));
        @(posedge clk) warning_event <= 1'b0;
        m({g(1, 1, 1, 1, 0), 24'h0});
        m({g(1, 0, 1, 1, 0), 24'h0});
        c("caut_clr", 8'h00, status_b0 & 8'h04);
        n = n_ds;
        m({g(1, 0, 1, 1, 1), 24'h0});
        c("set_go", 8'h01, 8'(n_ds - n));
        @(posedge clk) data_set_cmd <= 1'b0;
        m({g(0, 0, 1, 1, 0), 24'h0});
    endtask

    task t_power;
        @(posedge clk) param_busy <= 1'b1;
        s();
        c("rdy_param", 8'h00, status_b0 & 8'h40);
        @(posedge clk) begin
            param_busy <= 1'b0;
            module_reset <= 1'b1;
        end
        s();
        c("rdy_mreset", 8'h00, status_b0 & 8'h42);
        @(posedge clk) module_reset <= 1'b0;
        @(posedge clk) main_power <= 1'b0;
        s();
        c("no_supply", 8'h00, status_b0 & 8'h60);
        en_toggle();
        c("pwr_refuse", 8'h00, {7'h0, drive_on});
        @(posedge clk) main_power <= 1'b1;
        en_toggle();
        c("pwr_on", 8'h63, {status_b0[7:1], drive_on});
    endtask

    task end_sim;
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge clk);
        t_idle();
        t_move();
        t_rsp();
        t_fmt_abort();
        t_halt();
        t_alarm();
        t_warn();
        t_power();
        end_sim();
    end
endmodule
